// ==== rtl/timer_unit.sv ====
// Purpose: Four general timers, one wake-up timer and the interrupt flag logic
// Assumes: Event inputs are one-cycle pulses on core_clk; slow_oscillator is asynchronous
// Notes:   13.56 MHz and 212 kHz ticks are averaged rates from accumulators on core_clk
`timescale 1ns/1ps
`include "timer_unit_regs.svh"

// Operation
// - General timers select fast, slow or chain clock
// - Sixteen-bit counter readable as high/low bytes
// - Sixteen-bit reload value stored as two bytes
// - Wake-up timer always clocked by slow oscillator
// - Global control starts, stops, reports running timers
// - Running timer decrements once per timer tick
// - Interrupt raised one tick after reaching zero
// - Underflow halts or reloads per auto-reload bit
// - Host can set and clear timer flags
// - Apply-now with running bit starts, else stops
// - Start bit lets start event launch timer
// - Stop event before underflow stops, no flag
// - Stop event freezes count; flag marks underflow
// - Auto-reload with enable gives periodic interrupts
// - Auto-wake cycles standby around wake-up expiry
// - Underflow sets that timer's own flag
// - Transmit, receive, frame-start events set flags
// - Command completion sets command-done flag
// - FIFO warning levels set high/low flags
// - Receive error and card detection set flags
// - Any enabled flag sets the any-source flag
// - Bit seven chooses set or clear of bits
// - Interrupt sets summary bit and drives pin
module timer_unit #(
    parameter int N_GEN = 4
) (
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic             slow_oscillator,
    input  wire logic [N_GEN-1:0] start_event,
    input  wire logic [N_GEN-1:0] stop_event,
    input  wire logic             tx_end,
    input  wire logic             rx_end,
    input  wire logic             frame_start,
    input  wire logic             cmd_done,
    input  wire logic             fifo_high,
    input  wire logic             fifo_low,
    input  wire logic             comm_error,
    input  wire logic             card_found,
    input  wire logic             probe_done,
    output logic                  irq,
    output logic                  standby,
    input  wire logic [7:0]       awaddr,
    input  wire logic             awvalid,
    output logic                  awready,
    input  wire logic [31:0]      wdata,
    input  wire logic [3:0]       wstrb,
    input  wire logic             wvalid,
    output logic                  wready,
    output logic [1:0]            bresp,
    output logic                  bvalid,
    input  wire logic             bready,
    input  wire logic [7:0]       araddr,
    input  wire logic             arvalid,
    output logic                  arready,
    output logic [31:0]           rdata,
    output logic [1:0]            rresp,
    output logic                  rvalid,
    input  wire logic             rready
);

    timer_unit_pkg::state_s s_q;
    timer_unit_pkg::state_s s_d;

    logic [15:0] fast_sum;
    logic [15:0] slow_sum;
    logic        fast_tick;
    logic        slow_tick;
    logic        osc_tick;
    logic [4:0]  tick;
    logic [4:0]  uflow;
    logic [4:0]  applied;
    logic        do_write;
    logic [7:0]  wa;
    logic [7:0]  wd;
    logic [7:0]  t_rel;
    logic [2:0]  t_idx;
    logic [4:0]  t_ofs;
    logic        t_hit;
    logic [7:0]  ra;
    logic [7:0]  r_rel;
    logic [2:0]  r_idx;
    logic [4:0]  r_ofs;
    logic [7:0]  rd_val;
    logic        rd_err;
    logic        wr_err;
    logic        any_src;
    logic        wake_rise;

    always_comb begin
        s_d = s_q;
        // Accumulators keep the long-run tick rate exact without a second clock
        fast_sum  = {1'b0, s_q.acc_fast} + 16'(`FAST_KHZ);
        slow_sum  = {1'b0, s_q.acc_slow} + 16'(`SLOW_KHZ);
        fast_tick = fast_sum >= 16'(`CORE_KHZ);
        slow_tick = slow_sum >= 16'(`CORE_KHZ);
        s_d.acc_fast = fast_tick ? 15'(fast_sum - 16'(`CORE_KHZ)) : fast_sum[14:0];
        s_d.acc_slow = slow_tick ? 15'(slow_sum - 16'(`CORE_KHZ)) : slow_sum[14:0];
        s_d.osc_sync = {s_q.osc_sync[1:0], slow_oscillator};
        osc_tick     = s_q.osc_sync[1] & ~s_q.osc_sync[2];

        do_write = s_q.aw_got & s_q.w_got & ~s_q.bvalid;
        wa       = s_q.waddr;
        wd       = s_q.wdata;
        t_rel    = wa - `TMR_BASE;
        t_idx    = t_rel[7:5];
        t_ofs    = t_rel[4:0];
        t_hit    = (wa >= `TMR_BASE) && (wa < `TMR_END);
        ra       = araddr;
        r_rel    = ra - `TMR_BASE;
        r_idx    = r_rel[7:5];
        r_ofs    = r_rel[4:0];
        wr_err   = 1'b0;
        rd_err   = 1'b0;
        rd_val   = 8'h00;
        wake_rise = 1'b0;
        applied  = 5'b0_0000;

        // Host writes first, so hardware sets below win over a host clear
        if (do_write && s_q.wstb) begin
            if (wa == `FLAGS_A_OFS) begin
                if (wd[`SET_CLEAR_BIT]) begin
                    s_d.flags_a[6:0] = s_q.flags_a[6:0] | wd[6:0];
                end else begin
                    s_d.flags_a[6:0] = s_q.flags_a[6:0] & ~wd[6:0];
                end
            end else if (wa == `FLAGS_B_OFS) begin
                if (wd[`SET_CLEAR_BIT]) begin
                    s_d.flags_b[6:0] = s_q.flags_b[6:0] | wd[6:0];
                end else begin
                    s_d.flags_b[6:0] = s_q.flags_b[6:0] & ~wd[6:0];
                end
            end else if (wa == `FLAG_ENABLE_A_OFS) begin
                s_d.en_a = wd;
            end else if (wa == `FLAG_ENABLE_B_OFS) begin
                s_d.en_b = wd;
            end else if (wa == `GLOBAL_CTRL_OFS) begin
                for (int i = 0; i < N_GEN; i++) begin
                    if (wd[4+i]) begin
                        s_d.running[i] = wd[i];
                        // Host apply beats a same-cycle tick, so a restart keeps its reload
                        applied[i]     = 1'b1;
                        if (wd[i]) begin
                            s_d.count[i] = s_q.reload[i];
                        end
                    end
                end
            end else if (wa == `SUMMARY_OFS) begin
                wr_err = 1'b0;
            end else if (t_hit && t_ofs == `TMR_CTRL_OFS) begin
                s_d.ctrl[t_idx] = wd;
                if (t_idx == 3'd4) begin
                    wake_rise = wd[`AUTO_WAKE_BIT] & ~s_q.ctrl[4][`AUTO_WAKE_BIT];
                    applied[4] = 1'b1;
                    s_d.running[4] = wd[`WAKE_RUN_BIT];
                    if (wd[`WAKE_RUN_BIT]) begin
                        s_d.count[4] = s_q.reload[4];
                    end
                end
            end else if (t_hit && t_ofs == `TMR_RELOAD_HI_OFS) begin
                s_d.reload[t_idx][15:8] = wd;
            end else if (t_hit && t_ofs == `TMR_RELOAD_LO_OFS) begin
                s_d.reload[t_idx][7:0] = wd;
            end else if (t_hit && (t_ofs == `TMR_COUNT_HI_OFS || t_ofs == `TMR_COUNT_LO_OFS)) begin
                wr_err = 1'b0;
            end else begin
                wr_err = 1'b1;
            end
        end else if (do_write) begin
            wr_err = !((wa <= `SUMMARY_OFS) || t_hit);
        end

        // Wake-up timer runs first so its underflow can clock the chained timers
        tick[4] = osc_tick;
        uflow   = 5'b0_0000;
        for (int i = 0; i < N_GEN; i++) begin
            case (timer_unit_pkg::clk_sel_e'(s_q.ctrl[i][1:0]))
                timer_unit_pkg::SEL_FAST:  tick[i] = fast_tick;
                timer_unit_pkg::SEL_SLOW:  tick[i] = slow_tick;
                timer_unit_pkg::SEL_CHAIN: tick[i] = 1'b0;
                default:                   tick[i] = 1'b0;
            endcase
        end
        for (int k = 4; k >= 0; k--) begin
            if (k < N_GEN && s_q.ctrl[k][1:0] == 2'(timer_unit_pkg::SEL_CHAIN)) begin
                tick[k] = uflow[4];
            end
            if (k < N_GEN && s_q.running[k] && s_q.ctrl[k][`STOP_EVT_BIT] && stop_event[k]) begin
                // Stop before underflow: count frozen for reading, no flag
                s_d.running[k] = 1'b0;
            end else if (s_q.running[k] && tick[k] && !applied[k]) begin
                if (s_q.count[k] == 16'h0000) begin
                    uflow[k] = 1'b1;
                    if (s_q.ctrl[k][`AUTO_RELOAD_BIT]) begin
                        s_d.count[k] = s_q.reload[k];
                    end else begin
                        s_d.running[k] = 1'b0;
                    end
                end else begin
                    s_d.count[k] = s_q.count[k] - 16'h0001;
                end
            end
            if (k < N_GEN && !s_q.running[k] && s_q.ctrl[k][`START_EVT_BIT]
                    && start_event[k]) begin
                s_d.running[k] = 1'b1;
                s_d.count[k]   = s_q.reload[k];
            end
        end

        // Hardware sets
        s_d.flags_b[3:0] = s_d.flags_b[3:0] | uflow[3:0];
        s_d.flags_b[`WAKE_FLAG_BIT] = s_d.flags_b[`WAKE_FLAG_BIT] | uflow[4];
        s_d.flags_b[`CARD_FLAG_BIT] = s_d.flags_b[`CARD_FLAG_BIT] | card_found;
        s_d.flags_a[0] = s_d.flags_a[0] | tx_end;
        s_d.flags_a[1] = s_d.flags_a[1] | rx_end;
        s_d.flags_a[2] = s_d.flags_a[2] | cmd_done;
        s_d.flags_a[3] = s_d.flags_a[3] | fifo_high;
        s_d.flags_a[4] = s_d.flags_a[4] | fifo_low;
        s_d.flags_a[5] = s_d.flags_a[5] | comm_error;
        s_d.flags_a[6] = s_d.flags_a[6] | frame_start;
        s_d.flags_a[7] = 1'b0;
        s_d.flags_b[7] = 1'b0;

        any_src = |(s_d.flags_a[6:0] & s_d.en_a[6:0])
                | |(s_d.flags_b[5:0] & s_d.en_b[5:0]);
        s_d.flags_b[`ANY_FLAG_BIT] = any_src;
        s_d.irq_pin = any_src & s_d.en_b[`IRQ_OUT_EN_BIT];

        // Standby sequencing: sleep, wake on expiry, probe, back to sleep if empty
        case (s_q.power)
            timer_unit_pkg::PWR_FULL: begin
                if (wake_rise) begin
                    s_d.power = timer_unit_pkg::PWR_SLEEP;
                end
            end
            timer_unit_pkg::PWR_SLEEP: begin
                if (uflow[4]) begin
                    s_d.power = timer_unit_pkg::PWR_PROBE;
                end
            end
            timer_unit_pkg::PWR_PROBE: begin
                if (card_found) begin
                    s_d.power = timer_unit_pkg::PWR_FULL;
                end else if (probe_done) begin
                    s_d.power = timer_unit_pkg::PWR_SLEEP;
                end
            end
            default: begin
                s_d.power = timer_unit_pkg::PWR_FULL;
            end
        endcase
        if (!s_d.ctrl[4][`AUTO_WAKE_BIT]) begin
            s_d.power = timer_unit_pkg::PWR_FULL;
        end

        // AXI4-Lite write channel
        if (awvalid && s_q.awready) begin
            s_d.aw_got = 1'b1;
            s_d.waddr  = awaddr;
        end
        if (wvalid && s_q.wready) begin
            s_d.w_got = 1'b1;
            s_d.wdata = wdata[7:0];
            s_d.wstb  = wstrb[0];
        end
        if (do_write) begin
            s_d.aw_got = 1'b0;
            s_d.w_got  = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp  = wr_err ? `AXI_SLVERR : `AXI_OKAY;
        end else if (s_q.bvalid && bready) begin
            s_d.bvalid = 1'b0;
        end
        s_d.awready = ~s_d.aw_got & ~s_d.bvalid;
        s_d.wready  = ~s_d.w_got & ~s_d.bvalid;

        // AXI4-Lite read channel
        if (ra == `FLAGS_A_OFS) begin
            rd_val = s_q.flags_a;
        end else if (ra == `FLAGS_B_OFS) begin
            rd_val = s_q.flags_b;
        end else if (ra == `FLAG_ENABLE_A_OFS) begin
            rd_val = s_q.en_a;
        end else if (ra == `FLAG_ENABLE_B_OFS) begin
            rd_val = s_q.en_b;
        end else if (ra == `GLOBAL_CTRL_OFS) begin
            rd_val = {4'h0, s_q.running[3:0]};
        end else if (ra == `SUMMARY_OFS) begin
            rd_val = {5'h00, s_q.power, s_q.flags_b[`ANY_FLAG_BIT]};
        end else if (ra >= `TMR_BASE && ra < `TMR_END && r_ofs == `TMR_CTRL_OFS) begin
            rd_val = s_q.ctrl[r_idx];
        end else if (ra >= `TMR_BASE && ra < `TMR_END && r_ofs == `TMR_RELOAD_HI_OFS) begin
            rd_val = s_q.reload[r_idx][15:8];
        end else if (ra >= `TMR_BASE && ra < `TMR_END && r_ofs == `TMR_RELOAD_LO_OFS) begin
            rd_val = s_q.reload[r_idx][7:0];
        end else if (ra >= `TMR_BASE && ra < `TMR_END && r_ofs == `TMR_COUNT_HI_OFS) begin
            rd_val = s_q.count[r_idx][15:8];
        end else if (ra >= `TMR_BASE && ra < `TMR_END && r_ofs == `TMR_COUNT_LO_OFS) begin
            rd_val = s_q.count[r_idx][7:0];
        end else begin
            rd_err = 1'b1;
        end
        if (arvalid && s_q.arready) begin
            s_d.rvalid = 1'b1;
            s_d.rdata  = rd_val;
            s_d.rresp  = rd_err ? `AXI_SLVERR : `AXI_OKAY;
        end else if (s_q.rvalid && rready) begin
            s_d.rvalid = 1'b0;
        end
        s_d.arready = ~s_d.rvalid;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign irq     = s_q.irq_pin;
    assign standby = (s_q.power == timer_unit_pkg::PWR_SLEEP);
    assign awready = s_q.awready;
    assign wready  = s_q.wready;
    assign bvalid  = s_q.bvalid;
    assign bresp   = s_q.bresp;
    assign arready = s_q.arready;
    assign rvalid  = s_q.rvalid;
    assign rresp   = s_q.rresp;
    assign rdata   = {24'h00_0000, s_q.rdata};

endmodule // timer_unit

// ==== rtl/timer_unit_regs.svh ====
// Purpose: Register offsets, field positions and tick rates of the timer unit
// Assumes: 32-bit AXI4-Lite words, one aligned word per register, 8 data bits used
// Notes:   Timer blocks repeat at TMR_STRIDE starting at TMR_BASE
`ifndef TIMER_UNIT_REGS_SVH
`define TIMER_UNIT_REGS_SVH

`define FLAGS_A_OFS       8'h00
`define FLAGS_B_OFS       8'h04
`define FLAG_ENABLE_A_OFS 8'h08
`define FLAG_ENABLE_B_OFS 8'h0C
`define GLOBAL_CTRL_OFS   8'h10
`define SUMMARY_OFS       8'h14
`define TMR_BASE          8'h20
`define TMR_STRIDE        8'h20
`define TMR_END           8'hC0
`define TMR_CTRL_OFS      5'h00
`define TMR_RELOAD_HI_OFS 5'h04
`define TMR_RELOAD_LO_OFS 5'h08
`define TMR_COUNT_HI_OFS  5'h0C
`define TMR_COUNT_LO_OFS  5'h10

`define SET_CLEAR_BIT     7
`define IRQ_OUT_EN_BIT    7
`define AUTO_RELOAD_BIT   2
`define START_EVT_BIT     3
`define STOP_EVT_BIT      4
`define WAKE_RUN_BIT      6
`define AUTO_WAKE_BIT     7
`define WAKE_FLAG_BIT     4
`define CARD_FLAG_BIT     5
`define ANY_FLAG_BIT      6

`define AXI_OKAY          2'b00
`define AXI_SLVERR        2'b10

// Tick rates are produced by fractional accumulators on the core clock, in kHz
`define CORE_KHZ          20000
`define FAST_KHZ          13560
`define SLOW_KHZ          212

`endif

// ==== rtl/timer_unit_pkg.sv ====
// Purpose: Types shared by the timer unit
// Assumes: Constants live in timer_unit_regs.svh
// Notes:   The whole module state is one packed struct
package timer_unit_pkg;

    typedef enum logic [1:0] {
        SEL_FAST  = 2'b00,
        SEL_SLOW  = 2'b01,
        SEL_CHAIN = 2'b10,
        SEL_NONE  = 2'b11
    } clk_sel_e;

    typedef enum logic [1:0] {
        PWR_FULL  = 2'b00,
        PWR_SLEEP = 2'b01,
        PWR_PROBE = 2'b10
    } power_e;

    typedef struct packed {
        logic [14:0]      acc_fast;
        logic [14:0]      acc_slow;
        logic [2:0]       osc_sync;
        logic [7:0]       flags_a;
        logic [7:0]       flags_b;
        logic [7:0]       en_a;
        logic [7:0]       en_b;
        logic [4:0][7:0]  ctrl;
        logic [4:0][15:0] reload;
        logic [4:0][15:0] count;
        logic [4:0]       running;
        power_e           power;
        logic             irq_pin;
        logic             awready;
        logic             wready;
        logic             bvalid;
        logic [1:0]       bresp;
        logic             aw_got;
        logic             w_got;
        logic [7:0]       waddr;
        logic [7:0]       wdata;
        logic             wstb;
        logic             arready;
        logic             rvalid;
        logic [1:0]       rresp;
        logic [7:0]       rdata;
    } state_s;

endpackage

// ==== tb/timer_unit_assertions.sv ====
// Purpose: Port-level checks of the timer unit register bus and outputs
// Assumes: Offsets and codes from timer_unit_regs.svh
// Notes:   Watches design ports, bus inputs and outputs; bound into every timer_unit
`timescale 1ns/1ps
`include "timer_unit_regs.svh"
module timer_unit_assertions (
    input wire logic        core_clk,
    input wire logic        rst,
    input wire logic        irq,
    input wire logic        standby,
    input wire logic        awvalid,
    input wire logic        awready,
    input wire logic        wvalid,
    input wire logic        wready,
    input wire logic [1:0]  bresp,
    input wire logic        bvalid,
    input wire logic        bready,
    input wire logic [7:0]  araddr,
    input wire logic        arvalid,
    input wire logic        arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0]  rresp,
    input wire logic        rvalid,
    input wire logic        rready
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    a_reset_quiet: assert property (disable iff (1'b0)
        rst |=> !bvalid && !rvalid && !irq && !awready && !arready)
        else $error("outputs not quiet after reset");
    a_write_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped early");
    a_read_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
        else $error("read response dropped early");
    a_write_block: assert property (bvalid |-> !awready && !wready)
        else $error("write accepted while response pending");
    a_read_block: assert property (rvalid |-> !arready)
        else $error("read accepted while data pending");
    a_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
        else $error("write response late");
    a_read_answer: assert property (arvalid && arready |=> rvalid)
        else $error("read data late");
    a_unmapped_read: assert property (arvalid && arready && araddr >= `TMR_END
        |=> rresp == `AXI_SLVERR && rdata == 32'h0000_0000)
        else $error("unmapped read not refused");
    a_byte_lane: assert property (rvalid |-> rdata[31:8] == 24'h00_0000)
        else $error("upper read bits not zero");

    c_write: cover property (bvalid && bready);
    c_read: cover property (rvalid && rready);
    c_irq: cover property ($rose(irq));
    c_standby: cover property ($rose(standby));
endmodule // timer_unit_assertions

bind timer_unit timer_unit_assertions timer_unit_assertions_i (.core_clk, .rst, .irq, .standby,
    .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready);

// ==== tb/tb_timer_unit.sv ====
// Purpose: Self-checking bench of the timer unit over AXI4-Lite
// Assumes: Map and bit positions from timer_unit_regs.svh
// Notes:   Tick rates are averaged, so timer waits poll under a bound
`timescale 1ns/1ps
`include "timer_unit_regs.svh"
module tb_timer_unit;
    logic        core_clk = 0, rst = 1, slow_oscillator = 0, probe_done = 0;
    logic [3:0]  start_event = 0, stop_event = 0, wstrb = 0;
    logic [7:0]  ev = 0, awaddr = 0, araddr = 0;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [31:0] wdata = 0, rdata, rv, c1, m;
    logic [1:0]  bresp, rresp, rsp;
    logic        irq, standby, awready, wready, bvalid, arready, rvalid;
    int          n_mismatch = 0, comparisons = 0, cyc = 0;
    logic [31:0] seed = 32'h9957_bacc;

    timer_unit timer_unit_i (.core_clk, .rst, .slow_oscillator, .start_event, .stop_event,
        .tx_end(ev[0]), .rx_end(ev[1]), .cmd_done(ev[2]), .fifo_high(ev[3]),
        .fifo_low(ev[4]), .comm_error(ev[5]), .frame_start(ev[6]), .card_found(ev[7]),
        .probe_done, .irq, .standby, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
        .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
        .rvalid, .rready);

    always #25 core_clk = ~core_clk;
    // Free-running and unrelated to core_clk, as a real slow oscillator is
    always #1237 slow_oscillator = ~slow_oscillator;

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic summarize();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        awaddr  <= a;
        wdata   <= {24'h00_0000, d};
        wstrb   <= 4'hf;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge core_clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        rsp = bresp;
        bready <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic rd(input logic [7:0] a);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge core_clk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rv = rdata;
        rsp = rresp;
        rready <= 1'b0;
        @(posedge core_clk);
    endtask

    // Polls flags_b until bit b sets; the timer rate is only an average
    task automatic wait_b(input int b);
        rv = 0;
        for (int k = 0; k < 40 && rv[b] !== 1'b1; k++) rd(`FLAGS_B_OFS);
    endtask

    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            summarize();
        end
    end

    initial begin
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        repeat (2) @(posedge core_clk);
        check("irq_reset", irq, 1'b0);
        for (int i = 0; i < 2; i++) begin
            rd(i ? 8'hc0 : 8'h18);
            check("unmapped_rsp", rsp, `AXI_SLVERR);
        end
        for (int i = 0; i < 4; i++) begin
            m = xs();
            wr(`FLAGS_A_OFS, {1'b1, m[6:0]});
            wr(`FLAGS_B_OFS, {2'b10, m[13:8]});
            rd(`FLAGS_A_OFS);
            check("flags_a_set", rv, m[6:0]);
            rd(`FLAGS_B_OFS);
            check("flags_b_set", rv, m[13:8]);
            wr(`FLAGS_A_OFS, {1'b0, m[6:0]});
            wr(`FLAGS_B_OFS, {2'b00, m[13:8]});
            rd(`FLAGS_A_OFS);
            check("flags_a_clr", rv, 0);
            rd(`FLAGS_B_OFS);
            check("flags_b_clr", rv, 0);
        end
        for (int i = 0; i < 8; i++) begin
            ev <= 8'h01 << i;
            @(posedge core_clk);
            ev <= 8'h00;
            @(posedge core_clk);
            rd(i < 7 ? `FLAGS_A_OFS : `FLAGS_B_OFS);
            check("event_flag", rv, i < 7 ? 32'h1 << i : 32'h20);
            wr(i < 7 ? `FLAGS_A_OFS : `FLAGS_B_OFS, 8'h7f);
        end
        wr(`FLAG_ENABLE_A_OFS, 8'h01);
        wr(`FLAG_ENABLE_B_OFS, 8'h80);
        ev <= 8'h01;
        @(posedge core_clk);
        ev <= 8'h00;
        repeat (2) @(posedge core_clk);
        check("irq_on", irq, 1'b1);
        rd(`FLAGS_B_OFS);
        check("any_source", rv[6], 1'b1);
        rd(`SUMMARY_OFS);
        check("summary_bit", rv[0], 1'b1);
        wr(`FLAGS_A_OFS, 8'h01);
        repeat (2) @(posedge core_clk);
        check("irq_off", irq, 1'b0);
        // One-shot on timer a, fast clock, halting at zero
        wr(8'h20, 8'h00);
        wr(8'h24, 8'h00);
        wr(8'h28, 8'h05);
        wr(`FLAG_ENABLE_B_OFS, 8'h81);
        wr(`GLOBAL_CTRL_OFS, 8'h11);
        rd(8'h30);
        check("count_loaded", rv >= 1 && rv <= 5, 1'b1);
        wait_b(0);
        check("tmr_a_flag", rv[0], 1'b1);
        check("irq_timer", irq, 1'b1);
        rd(`GLOBAL_CTRL_OFS);
        check("a_halted", rv[0], 1'b0);
        rd(8'h30);
        check("a_count_zero", rv, 0);
        // Periodic on timer d with auto reload
        wr(8'h80, 8'h04);
        wr(8'h84, 8'h00);
        wr(8'h88, 8'h04);
        wr(`GLOBAL_CTRL_OFS, 8'h88);
        wait_b(3);
        wr(`FLAGS_B_OFS, 8'h08);
        wait_b(3);
        check("tmr_d_again", rv[3], 1'b1);
        rd(`GLOBAL_CTRL_OFS);
        check("d_running", rv[3], 1'b1);
        wr(`GLOBAL_CTRL_OFS, 8'h80);
        rd(`GLOBAL_CTRL_OFS);
        check("d_stopped", rv[3], 1'b0);
        // Stop event on timer b before underflow
        m = xs();
        wr(8'h40, 8'h10);
        wr(8'h44, {1'b1, m[6:0]});
        wr(8'h48, m[15:8]);
        wr(`GLOBAL_CTRL_OFS, 8'h22);
        stop_event <= 4'h2;
        @(posedge core_clk);
        stop_event <= 4'h0;
        @(posedge core_clk);
        rd(`GLOBAL_CTRL_OFS);
        check("b_stopped", rv[1], 1'b0);
        rd(8'h4c);
        c1 = rv;
        check("b_count_hi", c1 <= {1'b1, m[6:0]} && c1 + 1 >= {1'b1, m[6:0]}, 1'b1);
        rd(8'h4c);
        check("b_frozen", rv, c1);
        rd(`FLAGS_B_OFS);
        check("b_no_flag", rv[1], 1'b0);
        // Start event on timer c with no clock selected
        wr(8'h60, 8'h0b);
        wr(8'h64, 8'h10);
        wr(8'h68, 8'h00);
        start_event <= 4'h4;
        @(posedge core_clk);
        start_event <= 4'h0;
        @(posedge core_clk);
        rd(`GLOBAL_CTRL_OFS);
        check("c_started", rv[2], 1'b1);
        rd(8'h6c);
        check("c_count_hi", rv, 32'h10);
        wr(8'h70, 8'h55);
        check("ro_write_rsp", rsp, `AXI_OKAY);
        rd(8'h70);
        check("c_count_lo", rv, 0);
        wr(`GLOBAL_CTRL_OFS, 8'h40);
        // Timer a counts wake-timer underflows, so both flags rise together
        wr(8'h20, 8'h02);
        wr(8'h28, 8'h00);
        wr(`GLOBAL_CTRL_OFS, 8'h11);
        wr(`FLAGS_B_OFS, 8'h7f);
        wr(8'ha0, 8'h44);
        wait_b(0);
        check("chain_tick", rv[4:0] & 5'h11, 5'h11);
        // Auto-wake enters standby
        wr(8'ha0, 8'h80);
        repeat (2) @(posedge core_clk);
        check("standby_on", standby, 1'b1);
        rd(`SUMMARY_OFS);
        check("power_sleep", rv[2:1], 2'b01);
        // Wake expiry probes, an empty probe sleeps again, a card wakes fully
        wr(`FLAGS_B_OFS, 8'h10);
        wr(8'ha0, 8'hc4);
        wait_b(4);
        rd(`SUMMARY_OFS);
        check("power_probe", rv[2:1], 2'b10);
        probe_done <= 1'b1;
        @(posedge core_clk);
        probe_done <= 1'b0;
        @(posedge core_clk);
        check("probe_sleep", standby, 1'b1);
        wr(`FLAGS_B_OFS, 8'h10);
        wait_b(4);
        ev <= 8'h80;
        @(posedge core_clk);
        ev <= 8'h00;
        @(posedge core_clk);
        rd(`SUMMARY_OFS);
        check("card_wake", rv[2:1], 2'b00);
        wr(8'ha0, 8'h00);
        repeat (2) @(posedge core_clk);
        check("standby_off", standby, 1'b0);
        summarize();
    end
endmodule // tb_timer_unit
